// >>> vsc_pkg.sv
package vsc_pkg;

   // channel counts
   localparam int unsigned NUM_LINKS      = 3;
   localparam int unsigned CH_PER_LINK    = 4;
   localparam int unsigned NUM_IN_CH      = NUM_LINKS * CH_PER_LINK;

   // clock and timing
   localparam int unsigned CLK_FREQ_HZ     = 125_000_000;
   localparam int unsigned PULSE_TIME_MS   = 100;
   localparam int unsigned PULSE_CYCLES    = (CLK_FREQ_HZ / 1000) * PULSE_TIME_MS;
   localparam int unsigned UPDATE_DELAY_US = 10;
   localparam int unsigned UPDATE_CYCLES   = (CLK_FREQ_HZ / 1_000_000) * UPDATE_DELAY_US;

   // bus geometry
   localparam int unsigned AV_ADDR_W   = 8;
   localparam int unsigned AV_DATA_W   = 32;
   localparam int unsigned DEV_SEL_BIT = 7;

   // register byte offsets
   localparam logic [6:0] OFS_SOURCE   = 7'h00;
   localparam logic [6:0] OFS_PULSE_EN = 7'h04;
   localparam logic [6:0] OFS_RX_SET   = 7'h08;
   localparam logic [6:0] OFS_EQ       = 7'h0c;
   localparam logic [6:0] OFS_TX_SET   = 7'h10;
   localparam logic [6:0] OFS_MODES    = 7'h14;
   localparam logic [6:0] OFS_STATUS   = 7'h18;
   localparam logic [6:0] OFS_ADDR_ID  = 7'h1c;

   // field positions
   localparam int unsigned RX_TERM_OFF_BIT = 0;
   localparam int unsigned TX_TERM_BIT     = 0;
   localparam int unsigned OUTPUT_CURRENT_LEVEL_BIT_BIT      = 1;
   localparam int unsigned OUTPUT_PREEMPHASIS_FIELD_LSB       = 2;
   localparam int unsigned MODE_OE_BIT     = 0;
   localparam int unsigned STAT_SERIAL_BIT = 0;
   localparam int unsigned STAT_WIN_BIT    = 1;
   localparam int unsigned STAT_PULSE_BIT  = 2;
   localparam int unsigned STAT_SRC_LSB    = 4;

   // reset values
   localparam logic [1:0]           RST_SOURCE   = 2'h0;
   localparam logic [NUM_IN_CH-1:0] RST_PULSE_EN = 12'h000;
   localparam logic                 RST_TERM_OFF = 1'b0;
   localparam logic [NUM_IN_CH-1:0] RST_EQ       = 12'h000;
   localparam logic                 RST_OUT_TERM = 1'b1;
   localparam logic                 RST_OE       = 1'b1;
   localparam logic [1:0]           RST_PE       = 2'h0;

   localparam logic [1:0] SRC_INVALID = 2'h3;

   // arbitrary value, upper bits of the slave identity
   localparam logic [5:0] SLAVE_ADDR_UPPER = 6'h15;

   typedef struct packed {
      logic [1:0]           src;
      logic [NUM_IN_CH-1:0] pulse_en;
      logic                 term_off;
      logic [NUM_IN_CH-1:0] eq;
      logic                 out_term;
      logic                 oe;
      logic                 ocl;
      logic [1:0]           pe;
   } vsc_cfg_t;

endpackage: vsc_pkg

// >>> vsc_timer_if.sv
`timescale 1ns/1ps
interface vsc_timer_if;
   logic start;
   logic busy;
   logic done;
   modport owner (output start, input busy, input done);
   modport timer (input start, output busy, output done);
endinterface: vsc_timer_if

// >>> vsc_timer.sv
`timescale 1ns/1ps
module vsc_timer #(
   parameter int unsigned CYCLES = 16
) (
   input  wire logic  sys_clk_i,
   input  wire logic  reset_i,
   vsc_timer_if.timer tmr
);
   localparam int unsigned   CW   = $clog2(CYCLES + 1);
   localparam logic [CW-1:0] LOAD = CW'(CYCLES - 1);

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic          busy;
      logic          done;
   } vsc_tmr_state_t;

   vsc_tmr_state_t state_reg;
   vsc_tmr_state_t state_next;

   // a start while busy restarts the count
   always_comb begin
      state_next      = state_reg;
      state_next.done = 1'b0;
      if (tmr.start) begin
         state_next.cnt  = LOAD;
         state_next.busy = 1'b1;
      end else if (state_reg.busy) begin
         if (state_reg.cnt == '0) begin
            state_next.busy = 1'b0;
            state_next.done = 1'b1;
         end else begin
            state_next.cnt = state_reg.cnt - 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign tmr.busy = state_reg.busy;
   assign tmr.done = state_reg.done;

endmodule: vsc_timer

// >>> vsc_switch_ctrl.sv
// Function
// - route one of three source links, all four channels together, to the output.
// - after any register access, register settings replace pins until reset.
// - one slave address bit comes from the address-select pin.
// - reset returns all control registers to defaults.
// - pulse-enabled input channels lose termination for 100 ms after each switch.
// - global off bit disconnects all input terminations; default connected.
// - under pin control terminations stay connected, no switch-off or pulsing.
// - under register control each channel picks 6 dB or 12 dB by its bit.
// - under pin control one equalizer pin sets all channels.
// - under register control the output termination bit switches termination.
// - under pin control output termination is always enabled.
// - outputs disabled when enable bit (register control) or enable pin (pin control) requests it.
// - after reset, current level comes from the current-level pin.
// - four pre-emphasis levels from register field or two pins.
// - under pin control two source-select pins choose the input link.
// - writes in an update window do not restart it; end applies latest.
`timescale 1ns/1ps
module vsc_switch_ctrl
   import vsc_pkg::*;
#(
   parameter int unsigned PULSE_CYCLES_P  = PULSE_CYCLES,
   parameter int unsigned UPDATE_CYCLES_P = UPDATE_CYCLES
) (
   input  wire logic                 sys_clk_i,
   input  wire logic                 reset_i,
   input  wire logic [AV_ADDR_W-1:0] avs_address_i,
   input  wire logic                 avs_read_i,
   input  wire logic                 avs_write_i,
   input  wire logic [AV_DATA_W-1:0] avs_writedata_i,
   input  wire logic [3:0]           avs_byteenable_i,
   output      logic [AV_DATA_W-1:0] avs_readdata_o,
   output      logic                 avs_waitrequest_o,
   input  wire logic                 slave_address_lsb_pin_i,
   input  wire logic [1:0]           pin_source_select_i,
   input  wire logic                 pin_equalizer_select_i,
   input  wire logic                 pin_output_enable_i,
   input  wire logic                 pin_output_current_level_i,
   input  wire logic [1:0]           pin_preemphasis_bits_i,
   output      logic [1:0]           source_select_o,
   output      logic [NUM_IN_CH-1:0] input_term_connect_o,
   output      logic [NUM_IN_CH-1:0] input_equalizer_level_o,
   output      logic                 output_term_enable_o,
   output      logic                 output_enable_o,
   output      logic                 output_current_level_o,
   output      logic [1:0]           output_preemphasis_o,
   output      logic                 serial_control_o
);

   typedef struct packed {
      vsc_cfg_t             regs;
      vsc_cfg_t             applied;
      logic                 serial_mode;
      logic                 waitreq;
      logic [AV_DATA_W-1:0] rdata;
      logic [NUM_IN_CH-1:0] term_conn;
   } vsc_top_state_t;

   vsc_top_state_t state_reg;
   vsc_top_state_t state_next;

   vsc_cfg_t             pin_cfg;
   vsc_cfg_t             sel_cfg;
   logic                 win_start;
   logic                 pulse_start;
   logic                 bus_req;
   logic                 dev_match;
   logic [6:0]           ofs;
   logic [AV_DATA_W-1:0] wmask;
   logic [AV_DATA_W-1:0] old_word;
   logic [AV_DATA_W-1:0] new_word;
   logic [AV_DATA_W-1:0] rd_word;

   vsc_timer_if win_if ();
   vsc_timer_if pulse_if ();

   vsc_timer #(
      .CYCLES (UPDATE_CYCLES_P)
   ) u_update_window (
      .sys_clk_i (sys_clk_i),
      .reset_i   (reset_i),
      .tmr       (win_if)
   );

   vsc_timer #(
      .CYCLES (PULSE_CYCLES_P)
   ) u_term_pulse (
      .sys_clk_i (sys_clk_i),
      .reset_i   (reset_i),
      .tmr       (pulse_if)
   );

   assign win_if.start   = win_start;
   assign pulse_if.start = pulse_start;

   // register word image, for read-back and masked writes
   function automatic logic [AV_DATA_W-1:0] reg_word(input vsc_cfg_t c, input logic [6:0] o);
      logic [AV_DATA_W-1:0] w;
      w = '0;
      if (o == OFS_SOURCE) begin
         w[1:0] = c.src;
      end else if (o == OFS_PULSE_EN) begin
         w[NUM_IN_CH-1:0] = c.pulse_en;
      end else if (o == OFS_RX_SET) begin
         w[RX_TERM_OFF_BIT] = c.term_off;
      end else if (o == OFS_EQ) begin
         w[NUM_IN_CH-1:0] = c.eq;
      end else if (o == OFS_TX_SET) begin
         w[TX_TERM_BIT]             = c.out_term;
         w[OUTPUT_CURRENT_LEVEL_BIT_BIT]              = c.ocl;
         w[OUTPUT_PREEMPHASIS_FIELD_LSB+1:OUTPUT_PREEMPHASIS_FIELD_LSB]   = c.pe;
      end else if (o == OFS_MODES) begin
         w[MODE_OE_BIT] = c.oe;
      end
      return w;
   endfunction: reg_word

   always_comb begin
      state_next  = state_reg;
      win_start   = 1'b0;
      pulse_start = 1'b0;
      ofs         = avs_address_i[6:0];
      bus_req     = (avs_read_i || avs_write_i) && state_reg.waitreq;
      dev_match   = avs_address_i[DEV_SEL_BIT] == slave_address_lsb_pin_i;
      wmask       = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                     {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
      old_word    = reg_word(state_reg.regs, ofs);
      new_word    = (old_word & ~wmask) | (avs_writedata_i & wmask);
      rd_word     = '0;

      // pin control: terminations fixed on, no pulsing, one eq pin for all
      pin_cfg.src      = (pin_source_select_i == SRC_INVALID) ?
                         state_reg.applied.src : pin_source_select_i;
      pin_cfg.pulse_en = '0;
      pin_cfg.term_off = 1'b0;
      pin_cfg.eq       = {NUM_IN_CH{pin_equalizer_select_i}};
      pin_cfg.out_term = 1'b1;
      pin_cfg.oe       = pin_output_enable_i;
      pin_cfg.ocl      = pin_output_current_level_i;
      pin_cfg.pe       = pin_preemphasis_bits_i;

      sel_cfg = state_reg.serial_mode ? state_reg.regs : pin_cfg;

      // register slave, one-cycle answer
      state_next.waitreq = 1'b1;
      if (bus_req) begin
         state_next.waitreq = 1'b0;
         if (dev_match) begin
            state_next.serial_mode = 1'b1;
            if (ofs == OFS_STATUS) begin
               rd_word[STAT_SERIAL_BIT]           = state_reg.serial_mode;
               rd_word[STAT_WIN_BIT]              = win_if.busy;
               rd_word[STAT_PULSE_BIT]            = pulse_if.busy;
               rd_word[STAT_SRC_LSB+1:STAT_SRC_LSB] = state_reg.applied.src;
            end else if (ofs == OFS_ADDR_ID) begin
               rd_word[6:0] = {SLAVE_ADDR_UPPER, slave_address_lsb_pin_i};
            end else begin
               rd_word = old_word;
            end
            if (avs_write_i) begin
               if (ofs == OFS_SOURCE) begin
                  // an out-of-range link number is dropped
                  if (new_word[1:0] != SRC_INVALID) begin
                     state_next.regs.src = new_word[1:0];
                  end
               end else if (ofs == OFS_PULSE_EN) begin
                  state_next.regs.pulse_en = new_word[NUM_IN_CH-1:0];
               end else if (ofs == OFS_RX_SET) begin
                  state_next.regs.term_off = new_word[RX_TERM_OFF_BIT];
               end else if (ofs == OFS_EQ) begin
                  state_next.regs.eq = new_word[NUM_IN_CH-1:0];
               end else if (ofs == OFS_TX_SET) begin
                  state_next.regs.out_term = new_word[TX_TERM_BIT];
                  state_next.regs.ocl      = new_word[OUTPUT_CURRENT_LEVEL_BIT_BIT];
                  state_next.regs.pe       = new_word[OUTPUT_PREEMPHASIS_FIELD_LSB+1:OUTPUT_PREEMPHASIS_FIELD_LSB];
               end else if (ofs == OFS_MODES) begin
                  state_next.regs.oe = new_word[MODE_OE_BIT];
               end
            end
         end
         state_next.rdata = avs_read_i ? rd_word : '0;
      end

      // apply now when idle, otherwise hold until the window closes
      if (win_if.done || (!win_if.busy && (sel_cfg != state_reg.applied))) begin
         state_next.applied = sel_cfg;
         win_start          = !win_if.done && (sel_cfg != state_reg.applied);
         pulse_start        = sel_cfg.src != state_reg.applied.src;
      end

      // pulse mask is the one applied now, so a later apply during the pulse changes it
      if (state_reg.applied.term_off) begin
         state_next.term_conn = '0;
      end else if (pulse_if.busy) begin
         state_next.term_conn = ~state_reg.applied.pulse_en;
      end else begin
         state_next.term_conn = '1;
      end

      if (reset_i) begin
         state_next.regs.src      = RST_SOURCE;
         state_next.regs.pulse_en = RST_PULSE_EN;
         state_next.regs.term_off = RST_TERM_OFF;
         state_next.regs.eq       = RST_EQ;
         state_next.regs.out_term = RST_OUT_TERM;
         state_next.regs.oe       = RST_OE;
         state_next.regs.ocl      = pin_output_current_level_i;
         state_next.regs.pe       = RST_PE;
         state_next.applied       = pin_cfg;
         state_next.applied.src   = (pin_source_select_i == SRC_INVALID) ?
                                    RST_SOURCE : pin_source_select_i;
         state_next.serial_mode   = 1'b0;
         state_next.waitreq       = 1'b1;
         state_next.rdata         = '0;
         state_next.term_conn     = '1;
         win_start                = 1'b0;
         pulse_start              = 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      state_reg <= state_next;
   end

   assign avs_readdata_o          = state_reg.rdata;
   assign avs_waitrequest_o       = state_reg.waitreq;
   assign source_select_o         = state_reg.applied.src;
   assign input_term_connect_o    = state_reg.term_conn;
   assign input_equalizer_level_o = state_reg.applied.eq;
   assign output_term_enable_o    = state_reg.applied.out_term;
   assign output_enable_o         = state_reg.applied.oe;
   assign output_current_level_o  = state_reg.applied.ocl;
   assign output_preemphasis_o    = state_reg.applied.pe;
   assign serial_control_o        = state_reg.serial_mode;

endmodule: vsc_switch_ctrl

// >>> vsc_switch_ctrl_sva.sv
`timescale 1ns/1ps
module vsc_switch_ctrl_sva
   import vsc_pkg::*;
(
   input wire logic                 sys_clk_i,
   input wire logic                 reset_i,
   input wire logic [AV_ADDR_W-1:0] avs_address_i,
   input wire logic                 avs_read_i,
   input wire logic                 avs_write_i,
   input wire logic                 avs_waitrequest_o,
   input wire logic                 slave_address_lsb_pin_i,
   input wire logic                 pin_output_current_level_i,
   input wire logic [1:0]           source_select_o,
   input wire logic [NUM_IN_CH-1:0] input_term_connect_o,
   input wire logic                 output_term_enable_o,
   input wire logic                 output_current_level_o,
   input wire logic                 serial_control_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);
   sequence s_taken;
      (avs_read_i || avs_write_i) && avs_waitrequest_o;
   endsequence
   sequence s_answer;
      !avs_waitrequest_o ##1 avs_waitrequest_o;
   endsequence
   AST_ONE_ANSWER: assert property (s_taken |=> s_answer)
      else $error("bus answer not one cycle");
   AST_RST_DEFAULT: assert property ($fell(reset_i) |-> !serial_control_o && &input_term_connect_o)
      else $error("defaults missing after reset");
   AST_FLAG_STICKY: assert property (serial_control_o |=> serial_control_o)
      else $error("control flag dropped");
   AST_FLAG_SET: assert property (s_taken ##0 avs_address_i[DEV_SEL_BIT] == slave_address_lsb_pin_i |=> serial_control_o)
      else $error("flag not set by access");
   AST_ADDR_MISS: assert property (!serial_control_o && avs_waitrequest_o && (avs_read_i || avs_write_i)
      && avs_address_i[DEV_SEL_BIT] != slave_address_lsb_pin_i |=> !serial_control_o)
      else $error("foreign address took control");
   AST_PIN_TERM_ON: assert property (!serial_control_o |-> &input_term_connect_o)
      else $error("input termination off in pin mode");
   AST_PIN_OUT_TERM: assert property (!serial_control_o |-> output_term_enable_o)
      else $error("output termination off in pin mode");
   AST_LINK_VALID: assert property (source_select_o != SRC_INVALID)
      else $error("no valid link routed");
   AST_OCL_RESET: assert property ($fell(reset_i) |-> ##[0:2] output_current_level_o == pin_output_current_level_i)
      else $error("current level not from pin after reset");
endmodule: vsc_switch_ctrl_sva

// >>> vsc_pin_board.sv
`timescale 1ns/1ps
module vsc_pin_board #(
   parameter logic ADDR_LSB = 1'b1
) (
   input  wire logic [1:0] src_req_i,
   input  wire logic       eq_req_i,
   input  wire logic       oe_req_i,
   input  wire logic [1:0] pe_req_i,
   input  wire logic       int_term_i,
   input  wire logic       ext_term_i,
   output      logic       slave_address_lsb_pin_o,
   output      logic [1:0] pin_source_select_o,
   output      logic       pin_equalizer_select_o,
   output      logic       pin_output_enable_o,
   output      logic       pin_output_current_level_o,
   output      logic [1:0] pin_preemphasis_bits_o
);
   // static jumpers; the bench moves them only just after a clock edge
   always_comb begin
      slave_address_lsb_pin_o    = ADDR_LSB;
      pin_source_select_o        = src_req_i;
      pin_equalizer_select_o     = eq_req_i;
      pin_preemphasis_bits_o     = pe_req_i;
      // the high level only when internal and external terminations share the load
      pin_output_current_level_o = int_term_i && ext_term_i;
      pin_output_enable_o        = oe_req_i && (int_term_i || ext_term_i);
   end
endmodule: vsc_pin_board

// >>> vsc_switch_ctrl_tb_top.sv
`timescale 1ns/1ps
module vsc_switch_ctrl_tb_top
   import vsc_pkg::*;
;
   localparam logic DEV = 1'b1;
   logic        sys_clk_i = 1'b0;
   logic        reset_i   = 1'b1;
   logic [7:0]  av_addr   = 8'h00;
   logic        av_rd     = 1'b0;
   logic        av_wr     = 1'b0;
   logic [31:0] av_wdata  = 32'h0;
   logic [31:0] av_rdata, q;
   logic        av_wait, a_pin, eq_pin, oe_pin, ocl_pin, oterm, oe_o, ocl_o, ser;
   logic [1:0]  src_req = 2'h2, pe_req = 2'h3, src_pin, pe_pin, src_o, pe_o;
   logic        eq_req = 1'b1, oe_req = 1'b1, ext_term = 1'b1;
   logic [11:0] tconn, eq_o;
   int          fails = 0, num_checks = 0;

   always #4 sys_clk_i = ~sys_clk_i;

   vsc_pin_board #(.ADDR_LSB(DEV)) i_vsc_pin_board (.src_req_i(src_req), .eq_req_i(eq_req),
      .oe_req_i(oe_req), .pe_req_i(pe_req), .int_term_i(oterm), .ext_term_i(ext_term),
      .slave_address_lsb_pin_o(a_pin), .pin_source_select_o(src_pin),
      .pin_equalizer_select_o(eq_pin), .pin_output_enable_o(oe_pin),
      .pin_output_current_level_o(ocl_pin), .pin_preemphasis_bits_o(pe_pin));

   // short counts keep the run brief; timing below derives from these
   vsc_switch_ctrl #(.PULSE_CYCLES_P(20), .UPDATE_CYCLES_P(8)) i_vsc_switch_ctrl (
      .sys_clk_i(sys_clk_i), .reset_i(reset_i), .avs_address_i(av_addr), .avs_read_i(av_rd),
      .avs_write_i(av_wr), .avs_writedata_i(av_wdata), .avs_byteenable_i(4'hf),
      .avs_readdata_o(av_rdata), .avs_waitrequest_o(av_wait), .slave_address_lsb_pin_i(a_pin),
      .pin_source_select_i(src_pin), .pin_equalizer_select_i(eq_pin),
      .pin_output_enable_i(oe_pin), .pin_output_current_level_i(ocl_pin),
      .pin_preemphasis_bits_i(pe_pin), .source_select_o(src_o), .input_term_connect_o(tconn),
      .input_equalizer_level_o(eq_o), .output_term_enable_o(oterm), .output_enable_o(oe_o),
      .output_current_level_o(ocl_o), .output_preemphasis_o(pe_o), .serial_control_o(ser));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask: chk

   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk_i);
   endtask: cyc

   task automatic bus(input logic w, input logic [6:0] ofs, input logic dv, input logic [31:0] d);
      int n;
      n = 0;
      av_addr <= {dv, ofs};
      av_wdata <= d;
      av_wr <= w;
      av_rd <= !w;
      do begin
         @(posedge sys_clk_i);
         n++;
      end while (av_wait !== 1'b0 && n < 20);
      if (n >= 20) fails++;
      q = av_rdata;
      av_wr <= 1'b0;
      av_rd <= 1'b0;
      @(posedge sys_clk_i);
   endtask: bus

   task automatic rdc(input logic [6:0] ofs, input logic dv, input logic [31:0] m, input logic [31:0] e);
      bus(1'b0, ofs, dv, 32'h0);
      chk(q & m, e);
   endtask: rdc

   task automatic do_reset();
      reset_i <= 1'b1;
      cyc(3);
      reset_i <= 1'b0;
      @(posedge sys_clk_i);
   endtask: do_reset

   task automatic stop_test();
      $display("checks=%0d mismatches=%0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask: stop_test

   initial begin
      #100000;
      fails++;
      stop_test();
   end

   initial begin
      do_reset();
      cyc(20);
      chk(32'(eq_o), 32'hfff);
      chk(32'(tconn), 32'hfff);
      chk(32'({oterm, ocl_o, oe_o, ser}), 32'he);
      for (int i = 0; i < 4; i++) begin
         pe_req <= 2'(i);
         src_req <= 2'(i);
         oe_req <= 1'(i);
         cyc(20);
         chk(32'(pe_o), 32'(i));
         chk(32'(src_o), (i == 3) ? 32'h2 : 32'(i));
         chk(32'(oe_o), 32'(i & 1));
      end
      $display("pin control test done");
      rdc(OFS_TX_SET, !DEV, 32'hffffffff, 32'h0);
      chk(32'(ser), 32'h0);
      rdc(OFS_ADDR_ID, DEV, 32'h7f, {25'h0, SLAVE_ADDR_UPPER, DEV});
      rdc(OFS_TX_SET, DEV, 32'hf, 32'h3);
      src_req <= 2'h1;
      cyc(20);
      chk(32'({src_o, pe_o, ser}), 32'h1);
      chk(32'(eq_o), 32'h0);
      $display("override test done");
      bus(1'b1, OFS_SOURCE, DEV, 32'h2);
      bus(1'b1, OFS_EQ, DEV, 32'ha5c);
      bus(1'b1, OFS_TX_SET, DEV, 32'h8);
      bus(1'b1, OFS_MODES, DEV, 32'h0);
      bus(1'b1, OFS_SOURCE, DEV, 32'h3);
      cyc(40);
      chk(32'(eq_o), 32'ha5c);
      chk(32'({src_o, pe_o, oterm, ocl_o, oe_o}), 32'h50);
      rdc(OFS_STATUS, DEV, 32'h31, 32'h21);
      rdc(7'h20, DEV, 32'hffffffff, 32'h0);
      $display("serial settings test done");
      bus(1'b1, OFS_SOURCE, DEV, 32'h0);
      bus(1'b1, OFS_SOURCE, DEV, 32'h1);
      chk(32'(src_o), 32'h0);
      cyc(20);
      chk(32'(src_o), 32'h1);
      bus(1'b1, OFS_PULSE_EN, DEV, 32'h0f0);
      cyc(40);
      bus(1'b1, OFS_SOURCE, DEV, 32'h2);
      cyc(3);
      chk(32'(tconn), 32'hf0f);
      cyc(30);
      chk(32'(tconn), 32'hfff);
      bus(1'b1, OFS_RX_SET, DEV, 32'h1);
      cyc(20);
      chk(32'(tconn), 32'h0);
      $display("window and termination test done");
      // external load removed, so the reset default must follow a low pin
      ext_term <= 1'b0;
      do_reset();
      chk(32'(ser), 32'h0);
      cyc(20);
      chk(32'({src_o, oterm}), 32'h3);
      chk(32'(ocl_o), 32'h0);
      rdc(OFS_PULSE_EN, DEV, 32'hffffffff, 32'h0);
      rdc(OFS_RX_SET, DEV, 32'hffffffff, 32'h0);
      rdc(OFS_TX_SET, DEV, 32'hf, 32'h1);
      $display("reset test done");
      stop_test();
   end
endmodule: vsc_switch_ctrl_tb_top

bind vsc_switch_ctrl vsc_switch_ctrl_sva i_vsc_switch_ctrl_sva (.sys_clk_i(sys_clk_i),
   .reset_i(reset_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
   .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
   .slave_address_lsb_pin_i(slave_address_lsb_pin_i),
   .pin_output_current_level_i(pin_output_current_level_i), .source_select_o(source_select_o),
   .input_term_connect_o(input_term_connect_o), .output_term_enable_o(output_term_enable_o),
   .output_current_level_o(output_current_level_o), .serial_control_o(serial_control_o));
